// file: dv/burst_sram_sva.sv
// concurrent checks on the link between controller end and memory end
`timescale 1ns/1ps
`default_nettype none
module burst_sram_sva (
  input wire logic i_clk, // clock
  input wire logic i_reset_n, // reset
  input wire logic processor_addr_strobe_n, // strobe
  input wire logic controller_addr_strobe_n, // strobe
  input wire logic burst_advance_n, // advance
  input wire logic global_write_n, // write
  input wire logic byte_write_enable_n, // byte write
  input wire logic chip_select_first_n, // select
  input wire logic chip_select_second, // select
  input wire logic chip_select_third_n, // select
  input wire logic output_enable_n, // oe
  input wire logic sleep_request, // sleep
  input wire logic dev_data_oe_n, // device drive
  input wire logic ctl_data_oe_n // controller drive
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence start_s;
    !controller_addr_strobe_n || !processor_addr_strobe_n;
  endsequence
  sequence idle_s;
    controller_addr_strobe_n && processor_addr_strobe_n;
  endsequence
  // ----------------------------------------
  // link checks
  // ----------------------------------------
  chk_start_selects: assert property (start_s |-> !chip_select_first_n && chip_select_second && !chip_select_third_n)
    else $error("access start without all selects");
  chk_advance_beats: assert property (start_s |=> (!burst_advance_n)[*3])
    else $error("burst beats not advanced");
  chk_advance_idle: assert property (!burst_advance_n |-> idle_s)
    else $error("advance with a strobe low");
  chk_write_tristate: assert property (!global_write_n |=> dev_data_oe_n)
    else $error("device drives after write");
  chk_drive_read: assert property (!dev_data_oe_n |-> global_write_n)
    else $error("device drives in write cycle");
  chk_no_contention: assert property (dev_data_oe_n || ctl_data_oe_n)
    else $error("both ends drive data");
  chk_read_clean: assert property (!controller_addr_strobe_n && global_write_n |-> byte_write_enable_n)
    else $error("byte write active on read start");
  chk_oe_high_off: assert property (output_enable_n && $past(output_enable_n) && $past(output_enable_n, 2)
    |-> dev_data_oe_n)
    else $error("device drives with oe high");
  chk_sleep_idle: assert property (sleep_request |-> idle_s)
    else $error("strobe during sleep");
  chk_sleep_recover: assert property ($fell(sleep_request) |-> idle_s[*2])
    else $error("strobe too soon after sleep");
endmodule // burst_sram_sva
`default_nettype wire

// file: dv/sync_burst_sram_interface_bench.sv
// bench: controller end and memory end joined, bursts checked against a model
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_interface_bench;
  import burst_sram_pkg::*;
  logic i_clk;
  logic i_reset_n;
  logic req, wr, slp, c_busy, d_busy, rvalid, sleeping;
  logic [addr_width-1:0] addr;
  logic [data_width-1:0] wdata, rdata;
  logic [15:0] lfsr;
  logic [data_width-1:0] mem [int];
  logic [addr_width-1:0] used [$];
  int error_cnt, comparisons, i, n;
  burst_sram_if link ();
  burst_sram_device i_burst_sram_device (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(1'h1), .bus(link),
    .o_sleeping(sleeping), .o_busy(d_busy));
  burst_sram_controller i_burst_sram_controller (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(1'h1),
    .i_req(req), .i_write(wr), .i_addr(addr), .i_wdata(wdata), .i_sleep(slp), .bus(link), .o_busy(c_busy),
    .o_rvalid(rvalid), .o_rdata(rdata));
  burst_sram_sva i_burst_sram_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .processor_addr_strobe_n(link.processor_addr_strobe_n), .controller_addr_strobe_n(link.controller_addr_strobe_n),
    .burst_advance_n(link.burst_advance_n), .global_write_n(link.global_write_n),
    .byte_write_enable_n(link.byte_write_enable_n), .chip_select_first_n(link.chip_select_first_n),
    .chip_select_second(link.chip_select_second), .chip_select_third_n(link.chip_select_third_n),
    .output_enable_n(link.output_enable_n), .sleep_request(link.sleep_request),
    .dev_data_oe_n(link.dev_data_oe_n), .ctl_data_oe_n(link.ctl_data_oe_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [data_width-1:0] seen, input logic [data_width-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one four-beat burst; the model stores or checks each interleaved beat
  // masked: first read after a deselected state, its first beat leaves the bus undriven
  task automatic burst(input logic w, input logic [addr_width-1:0] a, input bit masked = 1'b0);
    int got, k;
    got = 0;
    @(posedge i_clk);
    #1;
    req = 1'h1;
    wr = w;
    addr = a;
    wdata = {lfsr[1:0], lfsr};
    lfsr = step(lfsr);
    if (w) begin
      for (k = 0; k < 4; k++) mem[{a[15:2], a[1:0] ^ 2'(k)}] = wdata;
    end
    @(posedge i_clk);
    #1;
    req = 1'h0;
    for (k = 0; k < 60 && (c_busy !== 1'h0 || (!w && got < 4)); k++) begin
      @(negedge i_clk);
      if (rvalid === 1'h1 && !w) begin
        if (masked && got == 0) begin
          check(rdata, {data_width{1'b0}});
        end else begin
          check(rdata, mem[{a[15:2], a[1:0] ^ 2'(got)}]);
        end
        got++;
      end
    end
    if (k >= 60) begin
      error_cnt++;
      close_out();
    end
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    i_reset_n = 1'h0;
    req = 1'h0;
    wr = 1'h0;
    slp = 1'h0;
    addr = 16'h0000;
    wdata = 18'h00000;
    lfsr = 16'h0055;
    error_cnt = 0;
    comparisons = 0;
    repeat (16) @(posedge i_clk);
    #1;
    i_reset_n = 1'h1;
    // write then read back at once, every start offset in turn
    for (i = 0; i < 8; i++) begin
      used.push_back({lfsr[15:2], 2'(i)});
      lfsr = step(lfsr);
      burst(1'h1, used[i]);
      burst(1'h0, used[i]);
    end
    check(data_width'(link.burst_order), data_width'(burst_interleaved));
    @(posedge i_clk);
    #1;
    slp = 1'h1;
    for (n = 0; n < 20 && sleeping !== 1'h1; n++) @(negedge i_clk);
    check(data_width'(sleeping), data_width'(1'h1));
    @(posedge i_clk);
    #1;
    slp = 1'h0;
    for (n = 0; n < 20 && (sleeping !== 1'h0 || c_busy !== 1'h0); n++) @(negedge i_clk);
    check(data_width'(sleeping), data_width'(1'h0));
    check(data_width'(d_busy), data_width'(1'h0));
    // stored words survive sleep; reread with a shifted start offset
    for (i = 0; i < 8; i++) burst(1'h0, used[i] ^ 16'h0003, i == 0);
    close_out();
  end
endmodule // sync_burst_sram_interface_bench
`default_nettype wire

// file: src/burst_sram_controller.sv
// controller end: drives strobes, selects and write controls for one four-beat burst
`timescale 1ns/1ps
`default_nettype none
module burst_sram_controller
  import burst_sram_pkg::*;
(
  input wire logic i_clk, // 25 mhz clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_clk_en, // freezes all state when low
  input wire logic i_req, // start a burst, one-cycle pulse
  input wire logic i_write, // burst is a write
  input wire logic [addr_width-1:0] i_addr, // start address
  input wire logic [data_width-1:0] i_wdata, // data for every write beat
  input wire logic i_sleep, // ask the memory to sleep
  burst_sram_if.controller bus, // link pins
  output logic o_busy, // burst, sleep or recovery in progress
  output logic o_rvalid, // read beat valid, pulse
  output logic [data_width-1:0] o_rdata // read beat data
);
  typedef enum {st_idle, st_start, st_beat, st_sleep, st_recover} phase_type;
  typedef struct packed {
    phase_type phase;
    logic [1:0] beat;
    logic [1:0] rec;
    logic [addr_width-1:0] addr;
    logic wr;
    logic [data_width-1:0] wdata;
    logic rvalid;
    logic [data_width-1:0] rdata;
    logic [1:0] rd_pipe;
  } state_type;
  state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.rd_pipe = {s_q.rd_pipe[0], (s_q.phase == st_beat || s_q.phase == st_start) && !s_q.wr};
    if (s_q.rd_pipe[0]) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = bus.data_bus;
    end
    case (s_q.phase)
      st_idle: begin
        // only idle (deselected) when sleep is raised
        if (i_sleep) s_d.phase = st_sleep;
        else if (i_req) begin
          s_d.phase = st_start;
          s_d.addr = i_addr;
          s_d.wr = i_write;
          s_d.wdata = i_wdata;
          s_d.beat = 2'h0;
        end
      end
      st_start: s_d.phase = st_beat;
      st_beat: begin
        s_d.beat = 2'(s_q.beat + 2'h1);
        if (s_q.beat == 2'h2) s_d.phase = st_idle;
      end
      st_sleep: if (!i_sleep) begin
        s_d.phase = st_recover;
        s_d.rec = 2'h0;
      end
      st_recover: begin
        // keep selects and strobes idle for the recovery time
        s_d.rec = 2'(s_q.rec + 2'h1);
        if (s_q.rec == 2'(sleep_recovery_cycles - 1)) s_d.phase = st_idle;
      end
      default: s_d.phase = st_idle;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.phase <= st_idle;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  logic starting;
  assign starting = s_q.phase == st_start;
  assign bus.address = s_q.addr;
  assign bus.chip_select_first_n = !starting;
  assign bus.chip_select_second = starting;
  assign bus.chip_select_third_n = !starting;
  // start every access with the controller strobe; reads keep writes off
  assign bus.controller_addr_strobe_n = !starting;
  assign bus.processor_addr_strobe_n = 1'b1;
  assign bus.burst_advance_n = !(s_q.phase == st_beat);
  assign bus.global_write_n = !(s_q.wr && (starting || s_q.phase == st_beat));
  assign bus.byte_write_enable_n = 1'b1;
  assign bus.lane_a_write_sel_n = 1'b1;
  assign bus.lane_b_write_sel_n = 1'b1;
  // output enable released for whole write bursts
  // output enable low only around read bursts, so the device is off before any write
  assign bus.output_enable_n = !((starting || s_q.phase == st_beat) && !s_q.wr);
  assign bus.ctl_data_out = s_q.wdata;
  assign bus.ctl_data_oe_n = !(s_q.wr && (starting || s_q.phase == st_beat));
  assign bus.sleep_request = s_q.phase == st_sleep;
  assign bus.burst_order = burst_interleaved;
  assign o_busy = s_q.phase != st_idle;
  assign o_rvalid = s_q.rvalid;
  assign o_rdata = s_q.rdata;
endmodule // burst_sram_controller
`default_nettype wire

// file: src/burst_sram_device.sv
// memory device end: input registers, burst counter, write lanes, output control, sleep
`timescale 1ns/1ps
`default_nettype none
module burst_sram_device
  import burst_sram_pkg::*;
#(
  parameter int depth_words = 1 << addr_width
) (
  input wire logic i_clk, // 25 mhz clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_clk_en, // freezes all state when low
  burst_sram_if.device bus, // link pins
  output logic o_sleeping, // device is in sleep
  output logic o_busy // a burst is open
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [addr_width-1:2] upper;
    logic [1:0] start;
    logic [1:0] beat;
    logic active;
    logic was_deselected;
    logic first_read;
    logic pending_write;
    logic write_now;
    logic [lane_count-1:0] lanes;
    logic [data_width-1:0] rdata;
    logic drive;
    logic [1:0] sleep_sync;
    logic [1:0] sleep_cnt;
    logic sleeping;
  } state_type;

  state_type s_q, s_d;
  logic [data_width-1:0] mem [depth_words];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic selected, p_start, c_start, start, is_write;
  logic [lane_count-1:0] lanes;
  logic [addr_width-1:0] addr_next;
  logic [1:0] beat_next;

  always_comb begin
    s_d = s_q;
    selected = !bus.chip_select_first_n && bus.chip_select_second && !bus.chip_select_third_n;
    // processor strobe wins, but only with all three selects active
    p_start = selected && !bus.processor_addr_strobe_n;
    c_start = selected && bus.processor_addr_strobe_n && !bus.controller_addr_strobe_n;
    start = (p_start || c_start) && !s_q.sleeping;
    lanes = lane_writes(bus.global_write_n, bus.byte_write_enable_n,
                        {bus.lane_b_write_sel_n, bus.lane_a_write_sel_n});
    is_write = |lanes;
    beat_next = s_q.beat;
    // advance only when neither strobe is active
    if (!start && bus.burst_advance_n == 1'b0 && bus.processor_addr_strobe_n
        && bus.controller_addr_strobe_n && s_q.active) begin
      beat_next = 2'(s_q.beat + 2'h1);
    end
    // beat address from counter and order pin
    addr_next = {s_q.upper, burst_addr(bus.burst_order, s_q.start, beat_next)};
    s_d.write_now = 1'b0;
    s_d.beat = beat_next;
    // strobes and controls sampled on the clock: at a start here, and for beats and deselect below
    if (start) begin
      // load start bits into the counter
      s_d.upper = bus.address[addr_width-1:2];
      s_d.start = bus.address[1:0];
      s_d.beat = counter_reset;
      s_d.active = 1'b1;
      addr_next = bus.address;
      // processor start ignores write controls; controller write stores now
      s_d.write_now = c_start && !p_start && is_write;
      s_d.lanes = lanes;
      s_d.first_read = s_q.was_deselected && !(c_start && !p_start && is_write);
      s_d.was_deselected = 1'b0;
    end else begin
      s_d.first_read = 1'b0;
      if (s_q.active && !s_q.sleeping) begin
        s_d.write_now = is_write;
        s_d.lanes = lanes;
      end
      if (!bus.processor_addr_strobe_n || !bus.controller_addr_strobe_n) begin
        s_d.active = 1'b0;
        s_d.was_deselected = 1'b1;
      end
    end
    s_d.rdata = mem[addr_next];
    // tri-state once a write is seen
    s_d.pending_write = s_d.write_now;
    // sleep pin synchronised, then two clocks to enter or leave
    s_d.sleep_sync = {s_q.sleep_sync[0], bus.sleep_request};
    if (s_q.sleep_sync[1] != s_q.sleeping) begin
      s_d.sleep_cnt = 2'(s_q.sleep_cnt + 2'h1);
      if (s_q.sleep_cnt == 2'(sleep_cycles - 1)) begin
        s_d.sleeping = s_q.sleep_sync[1];
        s_d.sleep_cnt = 2'h0;
        s_d.active = 1'b0;
        s_d.write_now = 1'b0;
        s_d.was_deselected = 1'b1;
      end
    end else begin
      s_d.sleep_cnt = 2'h0;
    end
    // drive read data unless masked, writing, deselected, asleep or output enable high
    // output enable comes from logic on this clock, so it needs no synchroniser
    s_d.drive = s_d.active && !s_d.pending_write && !s_d.first_read && !bus.output_enable_n
                && !s_d.sleeping;
  end

  // ----------------------------------------------------------------
  // registers and memory write
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.was_deselected <= 1'b1;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  // write data is taken in the cycle the write is presented
  always_ff @(posedge i_clk) begin
    if (i_clk_en && s_d.write_now) begin
      for (int l = 0; l < lane_count; l++) begin
        if (s_d.lanes[l]) begin
          mem[s_d.active ? {s_d.upper, burst_addr(bus.burst_order, s_d.start, s_d.beat)} : '0]
            [l*lane_width +: lane_width] <= bus.data_bus[l*lane_width +: lane_width];
        end
      end
    end
  end

  assign bus.dev_data_out = s_q.rdata;
  assign bus.dev_data_oe_n = !s_q.drive;
  assign o_sleeping = s_q.sleeping;
  assign o_busy = s_q.active;
endmodule // burst_sram_device
`default_nettype wire

// file: src/burst_sram_if.sv
// link between the memory device end and its controller end
`timescale 1ns/1ps
`default_nettype none
interface burst_sram_if;
  import burst_sram_pkg::*;
  logic [addr_width-1:0] address;
  logic processor_addr_strobe_n;
  logic controller_addr_strobe_n;
  logic burst_advance_n;
  logic global_write_n;
  logic byte_write_enable_n;
  logic lane_a_write_sel_n;
  logic lane_b_write_sel_n;
  logic chip_select_first_n;
  logic chip_select_second;
  logic chip_select_third_n;
  logic output_enable_n;
  logic sleep_request;
  logic burst_order;
  logic [data_width-1:0] dev_data_out;
  logic dev_data_oe_n;
  logic [data_width-1:0] ctl_data_out;
  logic ctl_data_oe_n;
  logic [data_width-1:0] data_bus;
  // shared data wire resolved from both enables (low enable = driving)
  assign data_bus = !dev_data_oe_n ? dev_data_out : (!ctl_data_oe_n ? ctl_data_out : '0);
  modport device (
    input address, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    input global_write_n, byte_write_enable_n, lane_a_write_sel_n, lane_b_write_sel_n,
    input chip_select_first_n, chip_select_second, chip_select_third_n,
    input output_enable_n, sleep_request, burst_order, data_bus,
    output dev_data_out, dev_data_oe_n
  );
  modport controller (
    output address, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    output global_write_n, byte_write_enable_n, lane_a_write_sel_n, lane_b_write_sel_n,
    output chip_select_first_n, chip_select_second, chip_select_third_n,
    output output_enable_n, sleep_request, burst_order, ctl_data_out, ctl_data_oe_n,
    input data_bus
  );
endinterface
`default_nettype wire

// file: src/burst_sram_pkg.sv
// shared constants and functions for the burst memory front end and its controller
package burst_sram_pkg;
  localparam int addr_width = 16;
  localparam int lane_width = 9;
  localparam int lane_count = 2;
  localparam int data_width = lane_width * lane_count;
  // sleep entry and exit take this many clocks
  localparam int sleep_cycles = 2;
  localparam logic [1:0] counter_reset = 2'h0;
  localparam logic burst_interleaved = 1'h1;
  localparam logic burst_linear = 1'h0;
  localparam int clk_period_ps = 40000;
  localparam int clock_to_data_valid_ps = 6500;
  localparam int sleep_recovery_cycles = 2;

  // next burst address: interleaved xors the beat count, linear adds
  function automatic logic [1:0] burst_addr(input logic interleaved, input logic [1:0] start,
                                            input logic [1:0] beat);
    burst_addr = interleaved ? (start ^ beat) : 2'(start + beat);
  endfunction

  // a cycle writes when global write is low, or byte enable plus any select
  function automatic logic [lane_count-1:0] lane_writes(input logic gw_n, input logic bwe_n,
                                                       input logic [lane_count-1:0] sel_n);
    if (!gw_n) lane_writes = '1;
    else if (!bwe_n) lane_writes = ~sel_n;
    else lane_writes = '0;
  endfunction
endpackage
